// file: src/cc_clock_control.sv
// The AXI4-Lite slave port was left to the implementer.
`timescale 1ns/1ps
module cc_clock_control
	import cc_pkg::*;
#(
	parameter int unsigned FLASH_TICKS = FLASH_RC_TICKS
)(
	input  wire logic              aclk,                // 125 MHz system clock
	input  wire logic              aresetn,             // Synchronous reset, low
	input  wire logic [ADDR_W-1:0] s_axi_awaddr,        // Write address
	input  wire logic              s_axi_awvalid,       // Write address valid
	output logic                   s_axi_awready,       // Write address ready
	input  wire logic [31:0]       s_axi_wdata,         // Write data
	input  wire logic [3:0]        s_axi_wstrb,         // Write strobes
	input  wire logic              s_axi_wvalid,        // Write data valid
	output logic                   s_axi_wready,        // Write data ready
	output logic [1:0]             s_axi_bresp,         // Write response
	output logic                   s_axi_bvalid,        // Write response valid
	input  wire logic              s_axi_bready,        // Write response ready
	input  wire logic [ADDR_W-1:0] s_axi_araddr,        // Read address
	input  wire logic              s_axi_arvalid,       // Read address valid
	output logic                   s_axi_arready,       // Read address ready
	output logic [31:0]            s_axi_rdata,         // Read data
	output logic [1:0]             s_axi_rresp,         // Read response
	output logic                   s_axi_rvalid,        // Read data valid
	input  wire logic              s_axi_rready,        // Read data ready
	input  wire logic              pll_output_clock,    // 96 MHz PLL clock, sampled
	input  wire logic              external_8m_clock,   // 8 MHz clock, sampled
	input  wire logic              rc_osc_clock,        // Internal RC clock, sampled
	input  wire logic              pll_lock_in,         // Analog lock detector
	input  wire logic              clock_output_fuse,   // Clock-out fuse programmed
	input  wire logic              gpio_out,            // Normal pin function data
	input  wire logic              gpio_oe,             // Normal pin function enable
	output logic                   pll_enable,          // PLL run request
	output logic                   master_clock,        // Glitch-free mux output
	output logic                   cpu_clock,           // Prescaled core clock
	output logic                   cpu_tick,            // One pulse per core clock
	output logic                   clock_output_pin_o,  // Output pin data
	output logic                   clock_output_pin_oe, // Output pin enable
	output logic                   flash_write_busy,    // Flash write timer running
	output logic                   irq                  // Level interrupt
);

	// ----------------------------------------
	// Source edges
	// ----------------------------------------
	logic rc_rise;

	cc_edge u_rc_edge (
		.aclk    (aclk),
		.aresetn (aresetn),
		.sig     (rc_osc_clock),
		.level   (),
		.rise    (rc_rise),
		.fall    ()
	);

	// ----------------------------------------
	// Register bus
	// ----------------------------------------
	logic                  aw_held_reg;
	logic [9:0]            aw_idx_reg;
	logic                  w_held_reg;
	logic [7:0]            wdata_reg;
	logic                  wstrb0_reg;
	logic                  bvalid_reg;
	logic [1:0]            bresp_reg;
	logic                  rvalid_reg;
	logic [31:0]           rdata_reg;
	logic [1:0]            rresp_reg;
	logic                  do_write;
	logic                  do_read;
	logic [9:0]            ar_idx;
	logic [DIV_SEL_W-1:0]  div_sel_reg;
	logic                  mux_sel_reg;
	logic                  pll_on_reg;
	cc_evt_t               status_reg;
	cc_evt_t               mask_reg;
	cc_evt_t               evt;
	logic                  lock_flag;
	logic                  lock_flag_reg;
	logic                  flash_go;

	assign s_axi_awready = !aw_held_reg && !bvalid_reg;
	assign s_axi_wready  = !w_held_reg && !bvalid_reg;
	assign do_write      = aw_held_reg && w_held_reg && !bvalid_reg;
	assign s_axi_arready = !rvalid_reg;
	assign do_read       = s_axi_arvalid && !rvalid_reg;
	assign ar_idx        = s_axi_araddr[ADDR_W-1:2];
	assign s_axi_bvalid  = bvalid_reg;
	assign s_axi_bresp   = bresp_reg;
	assign s_axi_rvalid  = rvalid_reg;
	assign s_axi_rdata   = rdata_reg;
	assign s_axi_rresp   = rresp_reg;

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			aw_held_reg <= 1'b0;
			aw_idx_reg  <= 10'h000;
			w_held_reg  <= 1'b0;
			wdata_reg   <= 8'h00;
			wstrb0_reg  <= 1'b0;
		end else begin
			if (s_axi_awvalid && s_axi_awready) begin
				aw_held_reg <= 1'b1;
				aw_idx_reg  <= s_axi_awaddr[ADDR_W-1:2];
			end else if (do_write) begin
				aw_held_reg <= 1'b0;
			end
			if (s_axi_wvalid && s_axi_wready) begin
				w_held_reg <= 1'b1;
				wdata_reg  <= s_axi_wdata[7:0];
				wstrb0_reg <= s_axi_wstrb[0];
			end else if (do_write) begin
				w_held_reg <= 1'b0;
			end
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			bvalid_reg <= 1'b0;
			bresp_reg  <= RESP_OKAY;
		end else if (do_write) begin
			bvalid_reg <= 1'b1;
			case (aw_idx_reg)
				IDX_PRESCALE, IDX_PLLCTL, IDX_STATUS, IDX_MASK, IDX_FLASH: bresp_reg <= RESP_OKAY;
				default: bresp_reg <= RESP_SLVERR;
			endcase
		end else if (s_axi_bready) begin
			bvalid_reg <= 1'b0;
		end
	end

	// Writable fields; reserved codes leave the divider untouched
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			div_sel_reg <= PRESCALE_RESET[DIV_SEL_W-1:0];
			mux_sel_reg <= PLLCTL_RESET[PLLCTL_MUX_BIT];
			pll_on_reg  <= PLLCTL_RESET[PLLCTL_ON_BIT];
			mask_reg    <= '0;
		end else if (do_write && wstrb0_reg) begin
			case (aw_idx_reg)
				IDX_PRESCALE: begin
					if (wdata_reg[DIV_SEL_W-1:0] <= DIV_SEL_MAX) begin
						div_sel_reg <= wdata_reg[DIV_SEL_W-1:0];
					end
				end
				IDX_PLLCTL: begin
					mux_sel_reg <= wdata_reg[PLLCTL_MUX_BIT];
					pll_on_reg  <= wdata_reg[PLLCTL_ON_BIT];
				end
				IDX_MASK: mask_reg <= cc_evt_t'(wdata_reg[EVT_W-1:0]);
				default: ;
			endcase
		end
	end

	assign flash_go   = do_write && wstrb0_reg && aw_idx_reg == IDX_FLASH && wdata_reg[FLASH_GO_BIT];
	assign pll_enable = pll_on_reg;
	assign lock_flag  = pll_on_reg && pll_lock_in;

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			rvalid_reg <= 1'b0;
			rdata_reg  <= 32'h0000_0000;
			rresp_reg  <= RESP_OKAY;
		end else if (do_read) begin
			rvalid_reg <= 1'b1;
			rresp_reg  <= RESP_OKAY;
			rdata_reg  <= 32'h0000_0000;
			case (ar_idx)
				IDX_PRESCALE: rdata_reg[DIV_SEL_W-1:0] <= div_sel_reg;
				IDX_PLLCTL: begin
					rdata_reg[PLLCTL_MUX_BIT]  <= mux_sel_reg;
					rdata_reg[PLLCTL_LOCK_BIT] <= lock_flag;
					rdata_reg[PLLCTL_ON_BIT]   <= pll_on_reg;
				end
				IDX_STATUS: rdata_reg[EVT_W-1:0] <= status_reg;
				IDX_MASK:   rdata_reg[EVT_W-1:0] <= mask_reg;
				IDX_FLASH:  rdata_reg[FLASH_GO_BIT] <= flash_write_busy;
				default:    rresp_reg <= RESP_SLVERR;
			endcase
		end else if (s_axi_rready) begin
			rvalid_reg <= 1'b0;
		end
	end

	// ----------------------------------------
	// Events and interrupt
	// ----------------------------------------
	logic frozen_reg;
	logic freeze_now;
	logic flash_done;

	assign evt.lock       = lock_flag && !lock_flag_reg;
	assign evt.flash_done = flash_done;
	assign evt.freeze     = freeze_now;

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			lock_flag_reg <= 1'b0;
		end else begin
			lock_flag_reg <= lock_flag;
		end
	end

	// A new event in the clearing read's cycle survives
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			status_reg <= '0;
		end else if (do_read && ar_idx == IDX_STATUS) begin
			status_reg <= evt;
		end else begin
			status_reg <= status_reg | evt;
		end
	end

	assign irq = |(status_reg & mask_reg);

	// ----------------------------------------
	// Glitch-free source multiplexer
	// ----------------------------------------
	cc_mux_state_t mux_state_reg;
	logic          active_pll_reg;
	logic          master_clock_reg;
	logic          master_next;
	logic          active_src;
	logic          target_src;
	logic          master_rise;

	assign active_src = active_pll_reg ? pll_output_clock : external_8m_clock;
	assign target_src = mux_sel_reg ? pll_output_clock : external_8m_clock;

	// Old source parks low, output stays low, then new source starts low
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			mux_state_reg  <= MUX_RUN;
			active_pll_reg <= 1'b0;
		end else begin
			case (mux_state_reg)
				MUX_RUN: begin
					if (mux_sel_reg != active_pll_reg && !frozen_reg) begin
						mux_state_reg <= MUX_DRAIN;
					end
				end
				MUX_DRAIN: begin
					if (!active_src) begin
						mux_state_reg <= MUX_ARM;
					end
				end
				MUX_ARM: begin
					if (!target_src) begin
						mux_state_reg  <= MUX_RUN;
						active_pll_reg <= mux_sel_reg;
					end
				end
				default: mux_state_reg <= MUX_RUN;
			endcase
		end
	end

	// Stopping the PLL under its own clock starves the core until reset
	assign freeze_now = !frozen_reg && active_pll_reg && !pll_on_reg;

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			frozen_reg <= 1'b0;
		end else if (freeze_now) begin
			frozen_reg <= 1'b1;
		end
	end

	always_comb begin
		master_next = 1'b0;
		if (!frozen_reg && !freeze_now) begin
			case (mux_state_reg)
				MUX_RUN:   master_next = active_src;
				MUX_DRAIN: master_next = active_src;
				default:   master_next = 1'b0;
			endcase
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			master_clock_reg <= 1'b0;
		end else begin
			master_clock_reg <= master_next;
		end
	end

	assign master_clock = master_clock_reg;
	assign master_rise  = master_next && !master_clock_reg;

	// ----------------------------------------
	// Prescaler
	// ----------------------------------------
	logic [DIV_W-1:0] div_reg;
	logic [DIV_W-1:0] div_cnt_reg;
	logic [DIV_W-1:0] div_cnt_next;
	logic [DIV_W-1:0] div_eff;
	logic             boundary;
	logic             load_now;
	logic             cpu_clock_reg;
	logic             cpu_tick_reg;

	// Core cannot run undivided from the PLL
	assign div_eff = (div_sel_reg == '0 && active_pll_reg) ? PLL_UNDIV : cc_div_factor(div_sel_reg);
	assign boundary     = div_cnt_reg == div_reg - DIV_W'(1);
	assign load_now     = master_rise && boundary;
	assign div_cnt_next = boundary ? '0 : div_cnt_reg + DIV_W'(1);

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			div_reg     <= DIV_RESET;
			div_cnt_reg <= '0;
		end else if (master_rise) begin
			div_cnt_reg <= div_cnt_next;
			if (boundary) begin
				div_reg <= div_eff;
			end
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			cpu_clock_reg <= 1'b0;
			cpu_tick_reg  <= 1'b0;
		end else begin
			cpu_tick_reg <= load_now;
			if (div_reg == DIV_W'(1)) begin
				cpu_clock_reg <= master_next;
			end else if (master_rise) begin
				cpu_clock_reg <= div_cnt_next < (div_reg >> 1);
			end
		end
	end

	assign cpu_clock = cpu_clock_reg;
	assign cpu_tick  = cpu_tick_reg;

	// ----------------------------------------
	// Clock output pin
	// ----------------------------------------
	// In reset the divider is held, so the raw 8 MHz source stands in
	assign clock_output_pin_o  = clock_output_fuse ? (aresetn ? cpu_clock_reg : external_8m_clock) : gpio_out;
	assign clock_output_pin_oe = clock_output_fuse || gpio_oe;

	// ----------------------------------------
	// Flash write timer
	// ----------------------------------------
	logic [FLASH_CNT_W-1:0] flash_cnt_reg;
	logic                   flash_busy_reg;

	assign flash_done = flash_busy_reg && rc_rise && flash_cnt_reg == FLASH_CNT_W'(1);

	// Counted on RC edges so the time tracks the RC trim, not the bus clock
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			flash_busy_reg <= 1'b0;
			flash_cnt_reg  <= '0;
		end else if (flash_go && !flash_busy_reg) begin
			flash_busy_reg <= 1'b1;
			flash_cnt_reg  <= FLASH_CNT_W'(FLASH_TICKS);
		end else if (flash_busy_reg && rc_rise) begin
			flash_cnt_reg <= flash_cnt_reg - FLASH_CNT_W'(1);
			if (flash_done) begin
				flash_busy_reg <= 1'b0;
			end
		end
	end

	assign flash_write_busy = flash_busy_reg;

	// ----------------------------------------
	// Checks
	// ----------------------------------------
	default clocking cb @(posedge aclk); endclocking
	default disable iff (!aresetn);

	mux_follows_src_a: assert property (
		($past(aresetn) && mux_state_reg == MUX_RUN && $past(mux_state_reg) == MUX_RUN
			&& !frozen_reg && !$past(frozen_reg))
		|-> master_clock_reg == $past(active_pll_reg ? pll_output_clock : external_8m_clock))
		else $error("Master clock does not follow the selected source");

	lock_readback_a: assert property (
		(do_read && ar_idx == IDX_PLLCTL) |=> rdata_reg[PLLCTL_LOCK_BIT] == $past(pll_on_reg && pll_lock_in))
		else $error("Lock flag read back wrong");

	pll_start_a: assert property (
		(do_write && wstrb0_reg && aw_idx_reg == IDX_PLLCTL) |=> pll_enable == $past(wdata_reg[PLLCTL_ON_BIT]))
		else $error("PLL enable does not follow control write");

	freeze_hold_a: assert property (
		frozen_reg |=> (frozen_reg && !master_clock_reg && !cpu_tick) [*3])
		else $error("Clock runs after PLL stop under PLL clock");

	start_8m_a: assert property (
		$rose(aresetn) |-> (!active_pll_reg && div_sel_reg == '0 && div_reg == DIV_RESET))
		else $error("Start-up selection or divider wrong");

	no_runt_a: assert property (
		(mux_state_reg == MUX_ARM) |=> !master_clock_reg)
		else $error("Master clock high during source switch");

	div_boundary_a: assert property (
		$changed(div_reg) |-> $past(load_now))
		else $error("Divider changed away from boundary");

	pll_undiv_a: assert property (
		(load_now && active_pll_reg && div_sel_reg == '0) |=> div_reg == PLL_UNDIV)
		else $error("PLL undivided code does not give six");

	div_map_a: assert property (
		(load_now && !active_pll_reg) |=> div_reg == cc_div_factor($past(div_sel_reg)))
		else $error("Division factor mapping wrong");

	clkout_reset_a: assert property (@(posedge aclk) disable iff (1'b0)
		(clock_output_fuse && !aresetn) |-> (clock_output_pin_oe && clock_output_pin_o == external_8m_clock))
		else $error("Clock output stops during reset");

	clkout_run_a: assert property (
		(clock_output_fuse && aresetn) |-> (clock_output_pin_oe && clock_output_pin_o == cpu_clock_reg))
		else $error("Clock output pin not driven with core clock");

	flash_end_a: assert property (
		flash_done |=> (!flash_busy_reg && status_reg.flash_done))
		else $error("Flash timer end not flagged");

endmodule

// file: src/cc_pkg.sv
// Operation
// - Flash write timing counts internal RC oscillator.
// - Fuse routes core clock onto output pin.
// - Clock output keeps running during reset.
// - Control bit 7 selects PLL or 8 MHz.
// - Lock flag reads set once PLL stable.
// - Control bit 0 starts or stops PLL.
// - PLL stopped under PLL clock freezes CPU.
// - Prescale bits 3..0 select divider, 7..4 zero.
// - Division factor changes apply without further action.
// - Codes map 1,4,5,6,8,12,24,48,96; rest reserved.
// - PLL with code zero gives 16 MHz.
// - Prescaled clock feeds CPU and peripherals.
// - Prescale register resets to zero, undivided.
// - Multiplexer selects 8 MHz after start-up.
package cc_pkg;

	// ----------------------------------------
	// Timing
	// ----------------------------------------
	localparam longint unsigned CLK_HZ          = 125_000_000;
	localparam longint unsigned RC_OSC_HZ       = 10_000_000;
	localparam longint unsigned FLASH_WRITE_NS  = 4_000;
	localparam int unsigned     FLASH_RC_TICKS  = int'((FLASH_WRITE_NS * RC_OSC_HZ) / 1_000_000_000);
	localparam int unsigned     FLASH_CNT_W     = 16;

	// ----------------------------------------
	// Register map (index, byte address = 4 * index)
	// ----------------------------------------
	localparam int unsigned     ADDR_W          = 12;
	localparam logic [9:0]      IDX_PRESCALE    = 10'h061;
	localparam logic [9:0]      IDX_PLLCTL      = 10'h062;
	localparam logic [9:0]      IDX_STATUS      = 10'h063;
	localparam logic [9:0]      IDX_MASK        = 10'h064;
	localparam logic [9:0]      IDX_FLASH       = 10'h065;

	localparam int unsigned     PLLCTL_MUX_BIT  = 7;
	localparam int unsigned     PLLCTL_LOCK_BIT = 1;
	localparam int unsigned     PLLCTL_ON_BIT   = 0;
	localparam int unsigned     DIV_SEL_W       = 4;
	localparam int unsigned     FLASH_GO_BIT    = 0;
	localparam logic [7:0]      PRESCALE_RESET  = 8'h00;
	localparam logic [7:0]      PLLCTL_RESET    = 8'h00;

	localparam int unsigned     EVT_LOCK        = 0;
	localparam int unsigned     EVT_FLASH_DONE  = 1;
	localparam int unsigned     EVT_FREEZE      = 2;
	localparam int unsigned     EVT_W           = 3;

	localparam logic [1:0]      RESP_OKAY       = 2'h0;
	localparam logic [1:0]      RESP_SLVERR     = 2'h2;

	// ----------------------------------------
	// Divider
	// ----------------------------------------
	localparam int unsigned     DIV_W           = 7;
	localparam logic [6:0]      PLL_UNDIV       = 7'h06;
	localparam logic [6:0]      DIV_RESET       = 7'h01;
	localparam logic [3:0]      DIV_SEL_MAX     = 4'h8;

	typedef enum logic [1:0] {
		MUX_RUN   = 2'h0,
		MUX_DRAIN = 2'h1,
		MUX_ARM   = 2'h3
	} cc_mux_state_t;

	typedef struct packed {
		logic freeze;
		logic flash_done;
		logic lock;
	} cc_evt_t;

	function automatic logic [6:0] cc_div_factor(input logic [3:0] code);
		case (code)
			4'h0:    cc_div_factor = 7'h01;
			4'h1:    cc_div_factor = 7'h04;
			4'h2:    cc_div_factor = 7'h05;
			4'h3:    cc_div_factor = 7'h06;
			4'h4:    cc_div_factor = 7'h08;
			4'h5:    cc_div_factor = 7'h0C;
			4'h6:    cc_div_factor = 7'h18;
			4'h7:    cc_div_factor = 7'h30;
			4'h8:    cc_div_factor = 7'h60;
			default: cc_div_factor = 7'h01;
		endcase
	endfunction

endpackage

// file: src/cc_edge.sv
`timescale 1ns/1ps
module cc_edge
	import cc_pkg::*;
(
	input  wire logic aclk,    // System clock
	input  wire logic aresetn, // Synchronous reset
	input  wire logic sig,     // Sampled clock source
	output logic      level,   // Previous sample
	output logic      rise,    // Rising edge this cycle
	output logic      fall     // Falling edge this cycle
);

	logic level_reg;

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			level_reg <= 1'b0;
		end else begin
			level_reg <= sig;
		end
	end

	assign level = level_reg;
	assign rise  = sig & ~level_reg;
	assign fall  = ~sig & level_reg;

endmodule

// file: test/cc_clock_control_tb.sv
`timescale 1ns/1ps
module cc_clock_control_tb;
	import cc_pkg::*;

	logic              aclk = 0;
	logic              aresetn = 0;
	logic [ADDR_W-1:0] s_axi_awaddr = '0, s_axi_araddr = '0;
	logic              s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0;
	logic              s_axi_arvalid = 0, s_axi_rready = 0;
	logic [31:0]       s_axi_wdata = '0, s_axi_rdata;
	logic [3:0]        s_axi_wstrb = 4'hF;
	logic              s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
	logic [1:0]        s_axi_bresp, s_axi_rresp;
	logic              pll_output_clock = 0, external_8m_clock = 0, rc_osc_clock = 0;
	logic              pll_lock_in = 0, clock_output_fuse = 1, gpio_out = 1, gpio_oe = 0;
	logic              pll_enable, master_clock, cpu_clock, cpu_tick;
	logic              clock_output_pin_o, clock_output_pin_oe, flash_write_busy, irq;
	logic [3:0]        src_cnt = '0;
	int                miscompares = 0, samples_checked = 0, p, n;
	int                fac [9] = '{1, 4, 5, 6, 8, 12, 24, 48, 96};

	cc_clock_control #(.FLASH_TICKS(3)) u_cc_clock_control (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid,
		.s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
		.s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
		.s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .pll_output_clock, .external_8m_clock, .rc_osc_clock,
		.pll_lock_in, .clock_output_fuse, .gpio_out, .gpio_oe, .pll_enable, .master_clock, .cpu_clock,
		.cpu_tick, .clock_output_pin_o, .clock_output_pin_oe, .flash_write_busy, .irq);

	always #4 aclk = ~aclk;

	// ----------------------------------------
	// Sampled sources: 8 MHz = 8 cycles, PLL = 2, RC = 4
	// ----------------------------------------
	always @(posedge aclk) begin
		src_cnt           <= src_cnt + 4'h1;
		external_8m_clock <= src_cnt[2];
		pll_output_clock  <= src_cnt[0] & pll_enable; // A stopped PLL makes no clock
		rc_osc_clock      <= src_cnt[1];
	end

	// ----------------------------------------
	// Access and compare tasks
	// ----------------------------------------
	task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
		samples_checked++;
		if (g !== e) begin
			miscompares++;
			$display("Error %s expected %h seen %h", nm, e, g);
		end
	endtask

	task automatic wr(input logic [11:0] a, input logic [31:0] v, input logic [1:0] er);
		int k;
		@(posedge aclk);
		s_axi_awaddr  <= a;
		s_axi_wdata   <= v;
		s_axi_awvalid <= 1;
		s_axi_wvalid  <= 1;
		s_axi_bready  <= 1;
		k = 0;
		do begin
			@(posedge aclk);
			k++;
			if (s_axi_awready === 1'b1) s_axi_awvalid <= 0;
			if (s_axi_wready === 1'b1) s_axi_wvalid <= 0;
		end while (s_axi_bvalid !== 1'b1 && k < 50);
		s_axi_bready <= 0;
		chk("bvalid", 32'h0000_0001, {31'h0, s_axi_bvalid});
		chk("bresp", {30'h0, er}, {30'h0, s_axi_bresp});
	endtask

	task automatic rd(input logic [11:0] a, input logic [31:0] e, input logic [1:0] er);
		int k;
		@(posedge aclk);
		s_axi_araddr  <= a;
		s_axi_arvalid <= 1;
		s_axi_rready  <= 1;
		k = 0;
		do begin
			@(posedge aclk);
			k++;
			if (s_axi_arready === 1'b1) s_axi_arvalid <= 0;
		end while (s_axi_rvalid !== 1'b1 && k < 50);
		chk("rvalid", 32'h0000_0001, {31'h0, s_axi_rvalid});
		s_axi_rready <= 0;
		chk("rresp", {30'h0, er}, {30'h0, s_axi_rresp});
		chk("rdata", e, s_axi_rdata);
	endtask

	// Cycles between two core clock pulses
	task automatic tper(output int q);
		int k;
		k = 0;
		do begin
			@(posedge aclk);
			k++;
		end while (cpu_tick !== 1'b1 && k < 2000);
		q = 0;
		do begin
			@(posedge aclk);
			q++;
		end while (cpu_tick !== 1'b1 && q < 2000);
	endtask

	// Pin must carry the raw source while reset is held
	task automatic do_reset();
		@(posedge aclk);
		aresetn <= 0;
		repeat (3) @(posedge aclk);
		#1 chk("pin_in_reset", {31'h0, external_8m_clock}, {31'h0, clock_output_pin_o});
		repeat (2) @(posedge aclk);
		aresetn <= 1;
	endtask

	task automatic end_of_test();
		$display("compares %0d mismatches %0d", samples_checked, miscompares);
		if (miscompares == 0 && samples_checked > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask

	initial begin
		repeat (20000) @(posedge aclk);
		miscompares++;
		end_of_test();
	end

	// ----------------------------------------
	// Tests
	// ----------------------------------------
	initial begin
		do_reset();
		rd(12'h184, 32'h0000_0000, RESP_OKAY);
		rd(12'h188, 32'h0000_0000, RESP_OKAY);
		#1 chk("pin", {31'h0, cpu_clock}, {31'h0, clock_output_pin_o});
		chk("pin_oe", 32'h0000_0001, {31'h0, clock_output_pin_oe});
		@(posedge aclk);
		clock_output_fuse <= 0;
		gpio_out          <= 0;
		@(posedge aclk);
		chk("pin_gpio", 32'h0000_0000, {31'h0, clock_output_pin_o});
		chk("oe_gpio", 32'h0000_0000, {31'h0, clock_output_pin_oe});
		clock_output_fuse <= 1;
		for (int c = 0; c < 9; c++) begin
			wr(12'h184, c, RESP_OKAY);
			rd(12'h184, c, RESP_OKAY);
			tper(p);
			tper(p);
			chk("div_period", fac[c] * 8, p);
		end
		wr(12'h184, 32'h0000_0009, RESP_OKAY);
		rd(12'h184, 32'h0000_0008, RESP_OKAY);
		wr(12'h184, 32'h0000_00F3, RESP_OKAY);
		rd(12'h184, 32'h0000_0003, RESP_OKAY);
		wr(12'h184, 32'h0000_0000, RESP_OKAY);
		wr(12'h190, 32'h0000_0007, RESP_OKAY);
		wr(12'h188, 32'h0000_0001, RESP_OKAY);
		chk("pll_enable", 32'h0000_0001, {31'h0, pll_enable});
		pll_lock_in <= 1;
		repeat (4) @(posedge aclk);
		chk("irq_lock", 32'h0000_0001, {31'h0, irq});
		rd(12'h188, 32'h0000_0003, RESP_OKAY);
		rd(12'h18C, 32'h0000_0001, RESP_OKAY);
		chk("irq_clear", 32'h0000_0000, {31'h0, irq});
		wr(12'h188, 32'h0000_0081, RESP_OKAY);
		tper(p);
		tper(p);
		chk("pll_code0", 32'd12, p);
		wr(12'h184, 32'h0000_0001, RESP_OKAY);
		tper(p);
		tper(p);
		chk("pll_code1", 32'd8, p);
		wr(12'h188, 32'h0000_0001, RESP_OKAY);
		tper(p);
		tper(p);
		chk("ext_code1", 32'd32, p);
		wr(12'h184, 32'h0000_0000, RESP_OKAY);
		wr(12'h194, 32'h0000_0001, RESP_OKAY);
		rd(12'h194, 32'h0000_0001, RESP_OKAY);
		n = 0;
		while (flash_write_busy === 1'b1 && n < 200) begin
			@(posedge aclk);
			n++;
		end
		rd(12'h18C, 32'h0000_0002, RESP_OKAY);
		rd(12'h000, 32'h0000_0000, RESP_SLVERR);
		wr(12'h000, 32'h0000_00FF, RESP_SLVERR);
		s_axi_wstrb <= 4'h0;
		wr(12'h184, 32'h0000_0005, RESP_OKAY);
		s_axi_wstrb <= 4'hF;
		rd(12'h184, 32'h0000_0000, RESP_OKAY);
		wr(12'h188, 32'h0000_0081, RESP_OKAY);
		wr(12'h188, 32'h0000_0080, RESP_OKAY);
		repeat (20) @(posedge aclk);
		n = 0;
		repeat (300) begin
			@(posedge aclk);
			if (cpu_tick !== 1'b0 || master_clock !== 1'b0) n++;
		end
		chk("frozen_ticks", 32'd0, n);
		rd(12'h18C, 32'h0000_0004, RESP_OKAY);
		do_reset();
		rd(12'h188, 32'h0000_0000, RESP_OKAY);
		tper(p);
		tper(p);
		chk("after_reset", 32'd8, p);
		end_of_test();
	end
endmodule
